// ### rtl/ilm_mapper.sv
module ilm_mapper (
  input wire logic CLOCK_IN,                     // 20 MHz system clock
  input wire logic SYS_RST_IN,                   // Synchronous reset, active high
  input wire logic ACTIVE_MODE_IN,               // Device in an active mode
  input wire ilm_pkg::ilm_src_t SOURCES_IN,      // Source request levels
  output logic [ilm_pkg::ILM_LINES-1:0] IRQ_OUT, // Processor request lines
  output logic [2:0] TOP_LINE_OUT,               // Highest priority pending line
  output logic TOP_VALID_OUT                     // Any line pending
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Sources may sit in other clock domains (sleep clock), so all pass
  // the three-stage filter; costs four cycles of latency.
  // Limitation: a source pulse shorter than two cycles is filtered away.

  // ----------------------------------------------------------------
  // Line 0: wake from sleep
  // ----------------------------------------------------------------
  logic wake;

  ilm_sync u_sync_wake (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link_wake_request),
    .sync_out(wake)
  );

  // ----------------------------------------------------------------
  // Line 1: link-layer sources
  // ----------------------------------------------------------------
  logic fine_timer;
  logic coarse_timer;
  logic base_tick;
  logic active;

  logic sleep_end;
  logic link_fault;
  logic packet_rx;
  logic event_end;

  logic link_cipher;
  logic software_link_request;

  // Timers first; mode passes the same filter as the tick, so both
  // move on one edge and no half-gated tick reaches the line
  ilm_sync u_sync_fine_timer (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.fine_timer),
    .sync_out(fine_timer)
  );

  ilm_sync u_sync_coarse_timer (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.coarse_timer),
    .sync_out(coarse_timer)
  );

  // Tick must stand two cycles or more to be seen
  ilm_sync u_sync_base_tick (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.base_tick),
    .sync_out(base_tick)
  );

  ilm_sync u_sync_active (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(ACTIVE_MODE_IN),
    .sync_out(active)
  );

  // Radio activity sources
  ilm_sync u_sync_sleep_end (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.sleep_end),
    .sync_out(sleep_end)
  );

  ilm_sync u_sync_link_fault (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.link_fault),
    .sync_out(link_fault)
  );

  ilm_sync u_sync_packet_rx (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.packet_rx),
    .sync_out(packet_rx)
  );

  ilm_sync u_sync_event_end (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.event_end),
    .sync_out(event_end)
  );

  // Cipher finish and the software request
  ilm_sync u_sync_link_cipher (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.link_cipher),
    .sync_out(link_cipher)
  );

  // Software request is a level from the bus side, held until cleared
  ilm_sync u_sync_software_link_request (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.link.software_link_request),
    .sync_out(software_link_request)
  );

  // ----------------------------------------------------------------
  // Lines 2 and 3: reserved
  // ----------------------------------------------------------------
  // No source behind them; the combination below ties both low so
  // the processor never takes a stray vector there.

  // ----------------------------------------------------------------
  // Line 4: radio calibration
  // ----------------------------------------------------------------
  logic phy_cal;

  ilm_sync u_sync_phy_cal (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.digital_radio_phy_cal),
    .sync_out(phy_cal)
  );

  // ----------------------------------------------------------------
  // Line 5: bus arbiter
  // ----------------------------------------------------------------
  logic arbiter;

  ilm_sync u_sync_arbiter (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.arbiter),
    .sync_out(arbiter)
  );

  // ----------------------------------------------------------------
  // Line 6: crypto engine
  // ----------------------------------------------------------------
  logic cipher_hash;
  logic elliptic_curve;

  // Two engine sources share one line; software asks the engine which
  ilm_sync u_sync_cipher_hash (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.cipher_hash),
    .sync_out(cipher_hash)
  );

  ilm_sync u_sync_elliptic_curve (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .async_in(SOURCES_IN.elliptic_curve),
    .sync_out(elliptic_curve)
  );

  // ----------------------------------------------------------------
  // Line combination
  // ----------------------------------------------------------------
  logic [ilm_pkg::ILM_LINES-1:0] next_irq;
  logic link_any;

  always_comb
  begin
    // Nine sources share line 1
    link_any = 1'b0;
    link_any = link_any | fine_timer;
    link_any = link_any | coarse_timer;
    // Tick is gated here too, in case the source is not
    link_any = link_any | (base_tick & active);
    link_any = link_any | sleep_end;
    link_any = link_any | link_fault;
    link_any = link_any | packet_rx;
    link_any = link_any | event_end;
    link_any = link_any | link_cipher;
    link_any = link_any | software_link_request;
    next_irq = ilm_pkg::ILM_LINES_RESET;
    next_irq[ilm_pkg::ILM_LINE_WAKE] = wake;
    // Level, not pulse: stays high while any source pends
    next_irq[ilm_pkg::ILM_LINE_LINK] = link_any;
    next_irq[ilm_pkg::ILM_LINE_RSVD_A] = 1'b0;
    next_irq[ilm_pkg::ILM_LINE_RSVD_B] = 1'b0;
    next_irq[ilm_pkg::ILM_LINE_RFCAL] = phy_cal;
    next_irq[ilm_pkg::ILM_LINE_ARB] = arbiter;
    // Either engine source holds the line
    next_irq[ilm_pkg::ILM_LINE_CRYPTO] = cipher_hash | elliptic_curve;
  end

  // ----------------------------------------------------------------
  // Priority report
  // ----------------------------------------------------------------
  // Not used by the processor; gives a testable view of the order
  logic [2:0] next_top_line;
  logic next_top_valid;

  always_comb
  begin
    next_top_line = 3'h0;
    next_top_valid = 1'b0;
    // Mirrors the processor's tie-break: the lowest pending number wins
    if (next_irq[ilm_pkg::ILM_LINE_WAKE])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_WAKE);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_LINK])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_LINK);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_RSVD_A])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_RSVD_A);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_RSVD_B])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_RSVD_B);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_RFCAL])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_RFCAL);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_ARB])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_ARB);
      next_top_valid = 1'b1;
    end
    else if (next_irq[ilm_pkg::ILM_LINE_CRYPTO])
    begin
      next_top_line = 3'(ilm_pkg::ILM_LINE_CRYPTO);
      next_top_valid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Every pin comes from a flop, so the processor never sees a glitch
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      IRQ_OUT <= ilm_pkg::ILM_LINES_RESET;
    end
    else
    begin
      IRQ_OUT <= next_irq;
    end
  end

  // Report registered from the same next value, so it always agrees
  // with the lines on the same cycle
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      TOP_LINE_OUT <= 3'h0;
      TOP_VALID_OUT <= 1'b0;
    end
    else
    begin
      TOP_LINE_OUT <= next_top_line;
      TOP_VALID_OUT <= next_top_valid;
    end
  end

endmodule : ilm_mapper

// ### rtl/ilm_pkg.sv
package ilm_pkg;

  // ----------------------------------------------------------------
  // Request line numbering
  // ----------------------------------------------------------------
  localparam int ILM_LINES = 7;
  localparam int ILM_LINE_WAKE = 0;
  localparam int ILM_LINE_LINK = 1;
  localparam int ILM_LINE_RSVD_A = 2;
  localparam int ILM_LINE_RSVD_B = 3;
  localparam int ILM_LINE_RFCAL = 4;
  localparam int ILM_LINE_ARB = 5;
  localparam int ILM_LINE_CRYPTO = 6;

  // ----------------------------------------------------------------
  // Timing and synchroniser
  // ----------------------------------------------------------------
  localparam int ILM_CLOCK_HZ = 20000000;
  localparam int ILM_BASE_TIME_US = 625;
  localparam int ILM_COARSE_FACTOR = 16;
  localparam int ILM_BASE_TIME_CYCLES = (ILM_BASE_TIME_US * (ILM_CLOCK_HZ / 1000000));
  localparam int ILM_SYNC_STAGES = 3;
  localparam logic [6:0] ILM_LINES_RESET = 7'h00;
  localparam logic [ILM_SYNC_STAGES-1:0] ILM_SYNC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Source groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fine_timer;
    logic coarse_timer;
    logic base_tick;
    logic sleep_end;
    logic link_fault;
    logic packet_rx;
    logic event_end;
    logic link_cipher;
    logic software_link_request;
  } ilm_link_src_t;

  typedef struct packed {
    logic link_wake_request;
    ilm_link_src_t link;
    logic digital_radio_phy_cal;
    logic arbiter;
    logic cipher_hash;
    logic elliptic_curve;
  } ilm_src_t;

  localparam int ILM_SRC_W = $bits(ilm_src_t);

endpackage : ilm_pkg

// ### rtl/ilm_sync.sv
module ilm_sync (
  input wire logic CLOCK_IN,   // System clock
  input wire logic SYS_RST_IN, // Synchronous reset
  input wire logic async_in,   // Level from another domain
  output logic sync_out        // Filtered level
);

  logic [ilm_pkg::ILM_SYNC_STAGES-1:0] stages;
  logic [ilm_pkg::ILM_SYNC_STAGES-1:0] next_stages;
  logic next_sync_out;

  always_comb
  begin
    next_stages = {stages[ilm_pkg::ILM_SYNC_STAGES-2:0], async_in};
    next_sync_out = sync_out;
    // Stage 0 is never looked at; stages 1 and 2 must agree
    if (stages[1] == stages[2])
    begin
      next_sync_out = stages[2];
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      stages <= ilm_pkg::ILM_SYNC_RESET;
      sync_out <= 1'b0;
    end
    else
    begin
      stages <= next_stages;
      sync_out <= next_sync_out;
    end
  end

endmodule : ilm_sync

// ### sim/ilm_mapper_chk.sv
module ilm_mapper_chk (
  input wire logic CLOCK_IN,                     // Clock
  input wire logic SYS_RST_IN,                   // Reset
  input wire logic ACTIVE_MODE_IN,               // Active mode
  input wire ilm_pkg::ilm_src_t SOURCES_IN,      // Sources
  input wire logic [ilm_pkg::ILM_LINES-1:0] IRQ_OUT, // Lines
  input wire logic [2:0] TOP_LINE_OUT,           // Top line
  input wire logic TOP_VALID_OUT                 // Any pending
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lnk;
  logic tck;
  logic cry;
  // Eight stable samples cover sync plus output stage
  assign lnk = |(SOURCES_IN.link & 9'h1BF);
  assign tck = SOURCES_IN.link.base_tick & ACTIVE_MODE_IN;
  assign cry = SOURCES_IN.cipher_hash | SOURCES_IN.elliptic_curve;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_wake_on: assert property (SOURCES_IN.link_wake_request [*8] |-> IRQ_OUT[0])
    else $error("wake line low");
  chk_link_on: assert property (lnk [*8] |-> IRQ_OUT[1])
    else $error("link line low");
  chk_tick_gate: assert property (tck [*8] |-> IRQ_OUT[1])
    else $error("tick not on link line");
  chk_link_quiet: assert property ((!lnk && !tck) [*8] |-> !IRQ_OUT[1])
    else $error("link line high without cause");
  chk_rsvd_low: assert property (IRQ_OUT[3:2] == 2'h0)
    else $error("reserved line high");
  chk_rfcal_on: assert property (SOURCES_IN.digital_radio_phy_cal [*8] |-> IRQ_OUT[4])
    else $error("calibration line low");
  chk_arb_map: assert property (SOURCES_IN.arbiter [*8] |-> IRQ_OUT[5])
    else $error("arbiter line low");
  chk_crypto_or: assert property (cry [*8] |-> IRQ_OUT[6])
    else $error("crypto line low");
  chk_crypto_quiet: assert property (!cry [*8] |-> !IRQ_OUT[6])
    else $error("crypto line high without cause");
  chk_top_low: assert property (TOP_VALID_OUT |-> IRQ_OUT[TOP_LINE_OUT] &&
    ((IRQ_OUT & ((7'h01 << TOP_LINE_OUT) - 7'h01)) == 7'h00)) else $error("top line wrong");
  chk_idle_top: assert property (!TOP_VALID_OUT |-> (IRQ_OUT == 7'h00))
    else $error("lines high with no top line");
endmodule : ilm_mapper_chk
bind ilm_mapper ilm_mapper_chk ilm_mapper_chk_inst (.CLOCK_IN, .SYS_RST_IN, .ACTIVE_MODE_IN,
  .SOURCES_IN, .IRQ_OUT, .TOP_LINE_OUT, .TOP_VALID_OUT);

// ### sim/ilm_nvic_model.sv
module ilm_nvic_model (
  input wire logic clock_in,       // System clock
  input wire logic [6:0] lines_in, // Request lines
  output logic [6:0] pending_out   // Seen requests
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines are levels, so pending just follows them
  always_ff @(posedge clock_in)
  begin
    pending_out <= lines_in;
  end
endmodule : ilm_nvic_model

// ### sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic active = 1'b0;
  ilm_pkg::ilm_src_t src = '0;
  ilm_pkg::ilm_src_t s;
  logic [6:0] irq;
  logic [2:0] top_line;
  logic top_valid;
  logic [6:0] pending;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'hCBC0;
  int cycles = 0;
  ilm_mapper ilm_mapper_inst (.CLOCK_IN(clock), .SYS_RST_IN(rst), .ACTIVE_MODE_IN(active),
    .SOURCES_IN(src), .IRQ_OUT(irq), .TOP_LINE_OUT(top_line), .TOP_VALID_OUT(top_valid));
  ilm_nvic_model ilm_nvic_model_inst (.clock_in(clock), .lines_in(irq), .pending_out(pending));
  initial forever #25 clock = ~clock;
  function automatic logic [6:0] exp_lines(ilm_pkg::ilm_src_t v, logic a);
    return {v.cipher_hash | v.elliptic_curve, v.arbiter, v.digital_radio_phy_cal, 2'h0,
      |(v.link & 9'h1BF) | (v.link.base_tick & a), v.link_wake_request};
  endfunction : exp_lines
  function automatic logic [6:0] exp_top(logic [6:0] e);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 6; i >= 0; i--) if (e[i]) r = {3'h0, 1'b1, 3'(i)};
    return r;
  endfunction : exp_top
  task automatic cmp(string name, logic [6:0] exp, logic [6:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic apply(ilm_pkg::ilm_src_t v, logic a);
    logic [6:0] e;
    e = exp_lines(v, a);
    src <= v;
    active <= a;
    repeat (10) @(posedge clock);
    cmp("irq", e, irq);
    cmp("top", exp_top(e), {3'h0, top_valid, top_line});
    cmp("pending", e, pending);
  endtask : apply
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    apply('0, 1'b1);
    for (int i = 0; i < ilm_pkg::ILM_SRC_W; i++)
    begin
      apply(ilm_pkg::ilm_src_t'(1 << i), 1'b1);
    end
    s = '0;
    s.link.base_tick = 1'b1;
    apply(s, 1'b0);
    s.arbiter = 1'b1;
    s.link_wake_request = 1'b1;
    apply(s, 1'b1);
    repeat (60) apply(ilm_pkg::ilm_src_t'($random(seed)), 1'($random(seed)));
    // Reset in mid-run with random sources and the arbiter source held high
    s = ilm_pkg::ilm_src_t'($random(seed));
    s.arbiter = 1'b1;
    src <= s;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    cmp("irq reset", 7'h00, irq);
    cmp("top reset", 7'h00, {3'h0, top_valid, top_line});
    rst <= 1'b0;
    @(posedge clock);
    cmp("irq release", 7'h00, irq);
    apply(s, 1'b1);
    conclude();
  end
endmodule : testbench
